// file: hw/fiofvs_supervisor.sv
/*
 * Field I/O module supervisor: heartbeat watchdog, supply check, the
 * two three-input monitor gates, the host power-up handshake with its
 * link-loss timer, the parallel ports, the serial bit-rate tick and a
 * classic Wishbone register slave.
 * Assumes host frames arrive already decoded on sys_clk, and that pins
 * (inputs, supply good, power down, jumpers) are asynchronous.
 */
`include "fiofvs_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module fiofvs_supervisor
  import fiofvs_pkg::*;
#(
  parameter int unsigned CLK_HZ        = `FIOF_CLK_HZ,
  parameter int unsigned HB_TOGGLE_CYC = CLK_HZ / 1000 * `FIOF_HB_TOGGLE_MS,
  parameter int unsigned HB_LOSS_CYC   = CLK_HZ / 1000 * `FIOF_HB_LOSS_MS,
  parameter int unsigned LINK_LOSS_CYC = CLK_HZ / 1000 * `FIOF_LINK_LOSS_MS
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // Wishbone slave
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  // Decoded host frames and replies
  input  wire logic         cmdValid,
  input  wire logic [7:0]   cmdAddr,
  input  wire logic [1:0]   cmdKind,
  input  wire logic         cmdRestore,
  input  wire logic [101:0] cmdOutputs,
  output logic              rspValid,
  output logic              rspRestore,
  // Pins
  input  wire logic [117:0] fieldIn,
  output logic      [101:0] fieldOut,
  output logic              fieldOutOe,
  input  wire logic         supplyGood,
  input  wire logic         powerDown_n,
  input  wire logic [2:0]   baudSel,
  output logic              baudTick,
  output logic              heartbeatOut,
  output logic              fault_monitor_out,
  output logic              faultMonitorOe,
  output logic              voltage_monitor_out,
  output logic              voltageMonitorOe,
  output logic              linkLostOut
);

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  logic [117:0] inMeta_reg;
  logic [117:0] inSync_reg;
  logic         supMeta_reg;
  logic         supSync_reg;
  logic         pdMeta_reg;
  logic         pdSync_reg;
  logic [2:0]   baudMeta_reg;
  logic [2:0]   baudSync_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      inMeta_reg   <= '0;
      inSync_reg   <= '0;
      supMeta_reg  <= 1'b0;
      supSync_reg  <= 1'b0;
      pdMeta_reg   <= 1'b1;
      pdSync_reg   <= 1'b1;
      baudMeta_reg <= 3'h0;
      baudSync_reg <= 3'h0;
    end else begin
      inMeta_reg   <= fieldIn;
      inSync_reg   <= inMeta_reg;
      supMeta_reg  <= supplyGood;
      supSync_reg  <= supMeta_reg;
      pdMeta_reg   <= powerDown_n;
      pdSync_reg   <= pdMeta_reg;
      baudMeta_reg <= baudSel;
      baudSync_reg <= baudMeta_reg;
    end
  end

  // --------------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------------
  logic [31:0] ctrl_reg;
  wire         wbReq     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire         ctrlWrite = wbReq & wb_we_i & (wb_adr_i == `FIOF_REG_CTRL);
  wire         hbRun     = ctrl_reg[`FIOF_CTRL_HB_RUN];

  wire [127:0] inPad = {10'h000, inSync_reg};
  wire [31:0]  inWord [4];

  genvar w;
  generate
    for (w = 0; w < 4; w++) begin : g_in_word
      assign inWord[w] = inPad[w*32 +: 32];
    end
  endgenerate

  // --------------------------------------------------------------------
  // Heartbeat generator and watchdog
  // --------------------------------------------------------------------
  logic [31:0] hbDiv_reg;
  logic        hbPrev_reg;
  logic [31:0] hbIdle_reg;
  logic        hbOk_reg;

  wire hbDivEnd = (hbDiv_reg == HB_TOGGLE_CYC - 1);
  wire hbEdge   = heartbeatOut ^ hbPrev_reg;
  wire hbExpire = (hbIdle_reg == HB_LOSS_CYC - 1);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hbDiv_reg    <= 32'h00000000;
      heartbeatOut <= 1'b0;
    end else if (!hbRun || hbDivEnd) begin
      hbDiv_reg    <= 32'h00000000;
      heartbeatOut <= heartbeatOut ^ hbRun;
    end else begin
      hbDiv_reg    <= hbDiv_reg + 32'h00000001;
    end
  end

  // The watchdog starts TRUE and falls only after a full silent window.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hbPrev_reg <= 1'b0;
      hbIdle_reg <= 32'h00000000;
      hbOk_reg   <= 1'b1;
    end else begin
      hbPrev_reg <= heartbeatOut;
      if (hbEdge) begin
        hbIdle_reg <= 32'h00000000;
        hbOk_reg   <= 1'b1;
      end else if (hbExpire) begin
        hbOk_reg   <= 1'b0;
      end else begin
        hbIdle_reg <= hbIdle_reg + 32'h00000001;
      end
    end
  end

  // --------------------------------------------------------------------
  // Host handshake and link-loss timer
  // --------------------------------------------------------------------
  fiofvs_link_t linkState_reg;
  fiofvs_link_t linkState_next;
  logic [31:0]  linkTimer_reg;
  logic         faultBit_reg;
  logic         voltBit_reg;
  logic [101:0] outLatch_reg;

  wire frameOk   = cmdValid & (cmdAddr == `FIOF_FRAME_ADDR);
  wire isStatus  = frameOk & (cmdKind == `FIOF_CMD_STATUS);
  wire isRestore = isStatus & cmdRestore;
  wire isOutput  = frameOk & (cmdKind == `FIOF_CMD_OUTPUT);
  wire linkUp    = (linkState_reg != LINK_DOWN);
  wire linkExpire = linkUp & (linkTimer_reg == LINK_LOSS_CYC - 1);
  wire takeOutput = isOutput & linkUp;

  always_comb begin
    linkState_next = linkState_reg;
    case (linkState_reg)
      LINK_DOWN: begin
        if (isRestore) begin
          linkState_next = WAIT_OUTPUT;
        end
      end
      WAIT_OUTPUT: begin
        if (linkExpire) begin
          linkState_next = LINK_DOWN;
        end else if (isOutput) begin
          linkState_next = RUNNING;
        end
      end
      RUNNING: begin
        if (linkExpire) begin
          linkState_next = LINK_DOWN;
        end
      end
      default: begin
        linkState_next = LINK_DOWN;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      linkState_reg <= LINK_DOWN;
      linkTimer_reg <= 32'h00000000;
    end else begin
      linkState_reg <= linkState_next;
      if (!linkUp || frameOk) begin
        linkTimer_reg <= 32'h00000000;
      end else if (!linkExpire) begin
        linkTimer_reg <= linkTimer_reg + 32'h00000001;
      end
    end
  end

  // Unit outputs into the gates; a loss drops them back to FALSE.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      faultBit_reg <= 1'b1;
      voltBit_reg  <= 1'b1;
      outLatch_reg <= '0;
    end else if (linkState_next == LINK_DOWN) begin
      faultBit_reg <= 1'b1;
      voltBit_reg  <= 1'b1;
      outLatch_reg <= '0;
    end else if (takeOutput) begin
      faultBit_reg <= cmdOutputs[`FIOF_FAULT_BIT];
      voltBit_reg  <= cmdOutputs[`FIOF_VOLT_BIT];
      outLatch_reg <= cmdOutputs;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rspValid   <= 1'b0;
      rspRestore <= 1'b0;
    end else begin
      rspValid   <= isStatus;
      rspRestore <= isRestore;
    end
  end

  // --------------------------------------------------------------------
  // Monitor gates and output pins
  // --------------------------------------------------------------------
  logic released_reg;
  logic pdSeen_reg;

  wire running   = (linkState_reg == RUNNING);
  wire unitFault = running & ~faultBit_reg;
  wire unitVolt  = running & ~voltBit_reg;
  // Each gate is TRUE only while all three of its inputs are TRUE.
  wire gateFault = hbOk_reg & supSync_reg & unitFault;
  wire gateVolt  = hbOk_reg & supSync_reg & unitVolt;
  wire pdNow     = ~pdSync_reg;

  // Once power down is seen only a reset brings the drivers back.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pdSeen_reg   <= 1'b0;
      released_reg <= 1'b1;
    end else begin
      pdSeen_reg   <= pdSeen_reg | pdNow;
      released_reg <= pdSeen_reg | pdNow;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_monitor_out   <= 1'b0;
      voltage_monitor_out <= 1'b0;
      faultMonitorOe      <= 1'b0;
      voltageMonitorOe    <= 1'b0;
      fieldOut            <= '0;
      fieldOutOe          <= 1'b0;
      linkLostOut         <= 1'b1;
    end else begin
      fault_monitor_out   <= gateFault;
      voltage_monitor_out <= gateVolt;
      faultMonitorOe      <= ~released_reg;
      voltageMonitorOe    <= ~released_reg;
      fieldOut            <= running ? outLatch_reg : '0;
      fieldOutOe          <= ~released_reg;
      linkLostOut         <= ~linkUp;
    end
  end

  // --------------------------------------------------------------------
  // Serial bit-rate tick
  // --------------------------------------------------------------------
  // Rounded to the nearest clock; the 300 bit/s divisor needs 17 bits.
  logic [31:0] baudDiv;
  logic [31:0] baudCnt_reg;

  always_comb begin
    case (baudSync_reg)
      3'h1:    baudDiv = (CLK_HZ + `FIOF_BAUD_1 / 2) / `FIOF_BAUD_1;
      3'h2:    baudDiv = (CLK_HZ + `FIOF_BAUD_2 / 2) / `FIOF_BAUD_2;
      3'h3:    baudDiv = (CLK_HZ + `FIOF_BAUD_3 / 2) / `FIOF_BAUD_3;
      3'h4:    baudDiv = (CLK_HZ + `FIOF_BAUD_4 / 2) / `FIOF_BAUD_4;
      3'h5:    baudDiv = (CLK_HZ + `FIOF_BAUD_5 / 2) / `FIOF_BAUD_5;
      3'h6:    baudDiv = (CLK_HZ + `FIOF_BAUD_6 / 2) / `FIOF_BAUD_6;
      default: baudDiv = (CLK_HZ + `FIOF_BAUD_0 / 2) / `FIOF_BAUD_0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      baudCnt_reg <= 32'h00000000;
      baudTick    <= 1'b0;
    end else if (baudCnt_reg >= baudDiv - 32'h00000001) begin
      baudCnt_reg <= 32'h00000000;
      baudTick    <= 1'b1;
    end else begin
      baudCnt_reg <= baudCnt_reg + 32'h00000001;
      baudTick    <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Wishbone slave
  // --------------------------------------------------------------------
  wire [31:0] statusWord = {25'h0000000,
                            released_reg,
                            running,
                            fault_monitor_out,
                            voltage_monitor_out ? 1'b1 : 1'b0,
                            supSync_reg,
                            hbOk_reg,
                            ~linkUp};
  wire [31:0] statusFix = {statusWord[31:5],
                           statusWord[3], statusWord[4],
                           statusWord[2:0]};

  logic [31:0] rdData;
  always_comb begin
    case (wb_adr_i)
      `FIOF_REG_CTRL:   rdData = ctrl_reg;
      `FIOF_REG_STATUS: rdData = statusFix;
      `FIOF_REG_IN0:    rdData = inWord[0];
      `FIOF_REG_IN1:    rdData = inWord[1];
      `FIOF_REG_IN2:    rdData = inWord[2];
      `FIOF_REG_IN3:    rdData = inWord[3];
      `FIOF_REG_BAUD:   rdData = {29'h00000000, baudSync_reg};
      default:          rdData = 32'h00000000;
    endcase
  end

  // Unmapped addresses are acknowledged, read zero and ignore writes.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl_reg <= `FIOF_CTRL_RESET;
    end else begin
      wb_ack_o <= wbReq;
      wb_dat_o <= wbReq ? rdData : 32'h00000000;
      if (ctrlWrite && wb_sel_i[0]) begin
        ctrl_reg[0] <= wb_dat_i[`FIOF_CTRL_HB_RUN];
      end
    end
  end

endmodule : fiofvs_supervisor

`default_nettype wire

// file: shared/fiofvs_defines.svh
/*
 * Constants of the field I/O fault and voltage supervisor: register
 * offsets, field positions, reset values, timing figures and codes.
 * Assumes inclusion by bare name from the package and the design.
 */
`ifndef FIOFVS_DEFINES_SVH
`define FIOFVS_DEFINES_SVH

// ----------------------------------------------------------------------
// Timing figures in their own units
// ----------------------------------------------------------------------
`define FIOF_CLK_HZ         20000000
`define FIOF_HB_TOGGLE_MS   100
`define FIOF_HB_LOSS_MS     2000
`define FIOF_LINK_LOSS_MS   1000

// ----------------------------------------------------------------------
// Serial bit rates in bit/s, selected by the jumper code
// ----------------------------------------------------------------------
`define FIOF_BAUD_0         300
`define FIOF_BAUD_1         1200
`define FIOF_BAUD_2         2400
`define FIOF_BAUD_3         4800
`define FIOF_BAUD_4         9600
`define FIOF_BAUD_5         19200
`define FIOF_BAUD_6         38400

// ----------------------------------------------------------------------
// Host frames
// ----------------------------------------------------------------------
`define FIOF_FRAME_ADDR     8'h14
`define FIOF_CMD_OTHER      2'h0
`define FIOF_CMD_STATUS     2'h1
`define FIOF_CMD_OUTPUT     2'h2
`define FIOF_FAULT_BIT      78
`define FIOF_VOLT_BIT       79
`define FIOF_IN_BITS        118
`define FIOF_OUT_BITS       102

// ----------------------------------------------------------------------
// Register offsets, fields and reset values
// ----------------------------------------------------------------------
`define FIOF_REG_CTRL       8'h00
`define FIOF_REG_STATUS     8'h04
`define FIOF_REG_IN0        8'h08
`define FIOF_REG_IN1        8'h0C
`define FIOF_REG_IN2        8'h10
`define FIOF_REG_IN3        8'h14
`define FIOF_REG_BAUD       8'h18
`define FIOF_CTRL_RESET     32'h00000001
`define FIOF_CTRL_HB_RUN    0
`define FIOF_ST_LINK_LOST   0
`define FIOF_ST_HB_OK       1
`define FIOF_ST_SUPPLY_OK   2
`define FIOF_ST_FAULT_MON   3
`define FIOF_ST_VOLT_MON    4
`define FIOF_ST_RUNNING     5
`define FIOF_ST_RELEASED    6

`endif

// file: shared/fiofvs_pkg.sv
/*
 * Types of the field I/O fault and voltage supervisor.
 * Assumes the constants header sits beside it on the include path.
 */
`include "fiofvs_defines.svh"

package fiofvs_pkg;

  // Power-up handshake with the host processor module.
  typedef enum logic [1:0] {
    LINK_DOWN,
    WAIT_OUTPUT,
    RUNNING
  } fiofvs_link_t;

endpackage : fiofvs_pkg

// file: testbench/fiofvs_supervisor_asserts.sv
/* Port checks of the field I/O supervisor, bound into its top module.
   Assumes the bind hands on the design's count parameters. */
`include "fiofvs_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module fiofvs_supervisor_asserts #(
  parameter int unsigned HB_TOGGLE_CYC = 20,
  parameter int unsigned HB_LOSS_CYC   = 100,
  parameter int unsigned LINK_LOSS_CYC = 200
) (
  input wire logic         sys_clk,
  input wire logic         rst_n,
  input wire logic         cmdValid,
  input wire logic [7:0]   cmdAddr,
  input wire logic [1:0]   cmdKind,
  input wire logic         cmdRestore,
  input wire logic [101:0] cmdOutputs,
  input wire logic         rspValid,
  input wire logic         rspRestore,
  input wire logic [101:0] fieldOut,
  input wire logic         fieldOutOe,
  input wire logic         supplyGood,
  input wire logic         powerDown_n,
  input wire logic         heartbeatOut,
  input wire logic         fault_monitor_out,
  input wire logic         voltage_monitor_out,
  input wire logic         linkLostOut
);
  logic        hbPrev;
  logic        hbArmed;
  int unsigned hbGap;
  int unsigned frameGap;
  wire         hbEdge  = heartbeatOut != hbPrev;
  wire         frameOk = cmdValid && cmdAddr == `FIOF_FRAME_ADDR;
  wire         monOff  = !fault_monitor_out && !voltage_monitor_out;

  // Counters stand in for long repetitions, which the tools unroll.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hbPrev   <= 1'b0;
      hbArmed  <= 1'b0;
      hbGap    <= 32'h0;
      frameGap <= 32'h0;
    end else begin
      hbPrev   <= heartbeatOut;
      hbArmed  <= hbEdge || (hbArmed && hbGap < HB_TOGGLE_CYC);
      hbGap    <= hbEdge ? 32'h0 : hbGap + 32'h1;
      frameGap <= frameOk ? 32'h0 : frameGap + 32'h1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence sQuery;
    frameOk && cmdKind == `FIOF_CMD_STATUS;
  endsequence
  sequence sUpdate;
    frameOk && cmdKind == `FIOF_CMD_OUTPUT && !linkLostOut;
  endsequence

  AST_SUPPLY_LOW:
    assert property (!supplyGood [*4] |-> monOff)
    else $error("monitor true while supply is bad");
  AST_LOST_MON:
    assert property (linkLostOut && $past(linkLostOut) |-> monOff)
    else $error("monitor true while link is lost");
  AST_QUERY_REPLY:
    assert property (sQuery |=> rspValid && rspRestore == $past(cmdRestore))
    else $error("status query not answered");
  AST_RESTORE_CLR:
    assert property (rspValid && rspRestore |=> !linkLostOut)
    else $error("link lost flag kept after restore");
  AST_WRONG_ADDR:
    assert property (cmdValid && !frameOk |=> !rspValid)
    else $error("reply to a foreign frame address");
  AST_UPDATE:
    assert property (sUpdate |-> ##2 (fieldOut == $past(cmdOutputs, 2)
      && !(fault_monitor_out && $past(cmdOutputs[78], 2))
      && !(voltage_monitor_out && $past(cmdOutputs[79], 2))))
    else $error("output update not applied");
  AST_HB_PERIOD:
    assert property (hbEdge && hbArmed |-> hbGap == HB_TOGGLE_CYC - 1)
    else $error("heartbeat period wrong");
  AST_HB_LOSS:
    assert property (hbGap > HB_LOSS_CYC + 2 |-> monOff)
    else $error("monitor true with heartbeat stopped");
  AST_LINK_TIMEOUT:
    assert property (frameGap > LINK_LOSS_CYC + 3 |->
      linkLostOut && fieldOut == 102'h0)
    else $error("link timeout not taken");
  AST_RELEASE:
    assert property (!powerDown_n [*5] |-> !fieldOutOe)
    else $error("outputs driven during power down");
endmodule : fiofvs_supervisor_asserts

bind fiofvs_supervisor fiofvs_supervisor_asserts #(
  .HB_TOGGLE_CYC(HB_TOGGLE_CYC),
  .HB_LOSS_CYC(HB_LOSS_CYC),
  .LINK_LOSS_CYC(LINK_LOSS_CYC)
) i_fiofvs_supervisor_asserts (.sys_clk, .rst_n, .cmdValid, .cmdAddr,
  .cmdKind, .cmdRestore, .cmdOutputs, .rspValid, .rspRestore, .fieldOut,
  .fieldOutOe, .supplyGood, .powerDown_n, .heartbeatOut,
  .fault_monitor_out, .voltage_monitor_out, .linkLostOut);
`default_nettype wire

// file: testbench/fiofvs_host_model.sv
/* Host processor model: sends decoded frames and collects replies.
   Assumes it is called just after a rising edge of sys_clk. */
`timescale 1ns/1ps
`default_nettype none
module fiofvs_host_model (
  input  wire logic         sys_clk,
  input  wire logic         rspValid,
  input  wire logic         rspRestore,
  output logic              cmdValid,
  output logic      [7:0]   cmdAddr,
  output logic      [1:0]   cmdKind,
  output logic              cmdRestore,
  output logic      [101:0] cmdOutputs
);
  initial begin
    cmdValid   = 1'b0;
    cmdAddr    = 8'h00;
    cmdKind    = 2'h0;
    cmdRestore = 1'b0;
    cmdOutputs = '0;
  end

  // Any frame order and spacing is allowed; lag makes a slow host.
  task automatic send(input logic [7:0] a, input logic [1:0] k,
                      input logic e, input logic [101:0] d, input int lag,
                      output logic got, output logic gotE);
    repeat (lag) @(posedge sys_clk);
    cmdValid   <= 1'b1;
    cmdAddr    <= a;
    cmdKind    <= k;
    cmdRestore <= e;
    cmdOutputs <= d;
    @(posedge sys_clk);
    // Released lines show the inverse so no stale value looks valid.
    cmdValid   <= 1'b0;
    cmdAddr    <= ~a;
    cmdKind    <= ~k;
    cmdRestore <= ~e;
    cmdOutputs <= ~d;
    got  = 1'b0;
    gotE = 1'b0;
    repeat (3) begin
      @(posedge sys_clk);
      if (rspValid === 1'b1) begin
        got  = 1'b1;
        gotE = rspRestore;
      end
    end
  endtask : send
endmodule : fiofvs_host_model
`default_nettype wire

// file: testbench/tb.sv
/* Self-checking bench of the field I/O supervisor with a host model.
   Assumes shortened watchdog and link counts set below. */
`include "fiofvs_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fiofvs_pkg::*;
  localparam int unsigned HB_T = 20;
  localparam int unsigned HB_L = 100;
  localparam int unsigned LINK_L = 400;
  localparam int unsigned BAUD6_DIV =
    (`FIOF_CLK_HZ + `FIOF_BAUD_6 / 2) / `FIOF_BAUD_6;
  logic sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, r;
  wire cmdValid, cmdRestore;
  wire [7:0] cmdAddr;
  wire [1:0] cmdKind;
  wire [101:0] cmdOutputs;
  logic rspValid, rspRestore, fieldOutOe, supplyGood, powerDown_n;
  logic heartbeatOut, fault_monitor_out, faultMonitorOe, linkLostOut;
  logic voltage_monitor_out, voltageMonitorOe;
  logic [117:0] fieldIn;
  logic [101:0] fieldOut, mOut;
  logic [2:0] baudSel;
  logic baudTick;
  wire [2:0] oeAll = {fieldOutOe, faultMonitorOe, voltageMonitorOe};
  logic [127:0] rnd;
  logic mLost, mRun, mSup, mHb;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  int gap;

  fiofvs_supervisor #(.HB_TOGGLE_CYC(HB_T), .HB_LOSS_CYC(HB_L),
    .LINK_LOSS_CYC(LINK_L)) i_fiofvs_supervisor (.sys_clk, .rst_n,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .cmdValid, .cmdAddr, .cmdKind, .cmdRestore,
    .cmdOutputs, .rspValid, .rspRestore, .fieldIn, .fieldOut, .fieldOutOe,
    .supplyGood, .powerDown_n, .baudSel, .baudTick, .heartbeatOut,
    .fault_monitor_out, .faultMonitorOe, .voltage_monitor_out,
    .voltageMonitorOe, .linkLostOut);
  fiofvs_host_model host (.sys_clk, .rspValid, .rspRestore, .cmdValid,
    .cmdAddr, .cmdKind, .cmdRestore, .cmdOutputs);

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 8000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic check(string nm, logic [127:0] seen, logic [127:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check

  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
  endtask : wb

  task automatic compare;
    logic ok;
    ok = !mLost && mRun && mSup && mHb;
    check("lost", linkLostOut, mLost);
    check("fault", fault_monitor_out, ok && !mOut[78]);
    check("volt", voltage_monitor_out, ok && !mOut[79]);
    check("out", fieldOut, mRun ? mOut : 102'h0);
  endtask : compare

  task automatic frame(input logic [7:0] a, input logic [1:0] k,
                       input logic e, input logic [101:0] d);
    logic got, gotE, ok;
    ok = (a == `FIOF_FRAME_ADDR);
    host.send(a, k, e, d, $urandom_range(3, 0), got, gotE);
    check("reply", got, ok && k == `FIOF_CMD_STATUS);
    if (got === 1'b1) check("restore", gotE, e);
    if (ok && k == `FIOF_CMD_STATUS && e) mLost = 1'b0;
    if (ok && k == `FIOF_CMD_OUTPUT && !mLost) begin
      mRun = 1'b1;
      mOut = d;
    end
    compare();
  endtask : frame

  task automatic reset;
    rst_n <= 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    {mLost, mRun, mSup, mHb, mOut} = {4'hB, 102'h0};
  endtask : reset

  initial begin
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    {supplyGood, powerDown_n, wb_sel_i, baudSel} = {6'h3F, 3'h0};
    void'($urandom(57));
    rnd = {$urandom(), $urandom(), $urandom(), $urandom()};
    fieldIn = rnd[117:0];
    reset();
    compare();
    check("oe", oeAll, 3'h7);
    baudSel <= 3'($urandom_range(6, 0));
    wb(1'b1, 8'h40, 32'hFFFFFFFF);
    wb(1'b0, 8'h40, 32'h0);
    check("unmapped", r, 32'h0);
    wb(1'b0, `FIOF_REG_CTRL, 32'h0);
    check("ctrl", r, `FIOF_CTRL_RESET);
    wb(1'b0, `FIOF_REG_BAUD, 32'h0);
    check("baud", r[2:0], baudSel);
    // The fastest rate keeps one tick period well inside the run.
    baudSel <= 3'h6;
    repeat (4) @(posedge sys_clk);
    do @(posedge sys_clk); while (baudTick !== 1'b1);
    gap = 0;
    do begin
      @(posedge sys_clk);
      gap++;
    end while (baudTick !== 1'b1 && gap < 1000);
    check("tick", gap, BAUD6_DIV);
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, 8'(`FIOF_REG_IN0 + 4 * i), 32'h0);
      check("in", r, 32'({10'h0, fieldIn} >> (32 * i)));
    end
    frame(8'h15, `FIOF_CMD_STATUS, 1'b1, '0);
    frame(8'h14, `FIOF_CMD_OUTPUT, 1'b0, '0);
    frame(8'h14, `FIOF_CMD_STATUS, 1'b0, '0);
    frame(8'h14, `FIOF_CMD_STATUS, 1'b1, '0);
    frame(8'h14, `FIOF_CMD_OTHER, 1'b0, '1);
    for (int k = 3; k >= 0; k--) begin
      rnd = {$urandom(), $urandom(), $urandom(), $urandom()};
      rnd[79:78] = 2'(k);
      frame(8'h14, `FIOF_CMD_OUTPUT, 1'b0, rnd[101:0]);
    end
    supplyGood <= 1'b0;
    repeat (5) @(posedge sys_clk);
    mSup = 1'b0;
    compare();
    supplyGood <= 1'b1;
    repeat (5) @(posedge sys_clk);
    mSup = 1'b1;
    compare();
    frame(8'h14, `FIOF_CMD_OTHER, 1'b0, '0);
    wb(1'b1, `FIOF_REG_CTRL, 32'h0);
    repeat (HB_L + 5) @(posedge sys_clk);
    mHb = 1'b0;
    compare();
    wb(1'b1, `FIOF_REG_CTRL, 32'h1);
    repeat (2 * HB_T + 5) @(posedge sys_clk);
    mHb = 1'b1;
    compare();
    frame(8'h14, `FIOF_CMD_OTHER, 1'b0, '0);
    repeat (LINK_L - 100) @(posedge sys_clk);
    frame(8'h14, `FIOF_CMD_OTHER, 1'b0, '0);
    repeat (LINK_L - 100) @(posedge sys_clk);
    compare();
    repeat (120) @(posedge sys_clk);
    {mLost, mRun} = 2'h2;
    compare();
    frame(8'h14, `FIOF_CMD_OUTPUT, 1'b0, '0);
    powerDown_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    powerDown_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    check("oe", oeAll, 3'h0);
    reset();
    check("oe", oeAll, 3'h7);
    compare();
    test_done();
  end
endmodule : tb
`default_nettype wire
